// [wsg_cnt_if.sv]
`timescale 1ns/1ps
interface wsg_cnt_if #(parameter int CNT_W = 5);
    logic load;
    logic [CNT_W-1:0] load_val;
    logic done;
    modport ctl (output load, output load_val, input done);
    modport cnt (input load, input load_val, output done);
endinterface

// [wsg_counter.sv]
`timescale 1ns/1ps
`include "wsg_params.svh"
module wsg_counter #(parameter int CNT_W = 5) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    wsg_cnt_if.cnt cif
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // ***********************************
    // Down-counter, one step per bus clock
    // ***********************************
    always_comb begin
        nxt_cnt = cnt_ff;
        if (cif.load) begin
            nxt_cnt = cif.load_val;
        end else if (cnt_ff != `WSG_CNT_ZERO) begin
            nxt_cnt = CNT_W'(cnt_ff - `WSG_CNT_ONE);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= CNT_W'(`WSG_CNT_ZERO);
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Last wait state in progress
    assign cif.done = (cnt_ff == `WSG_CNT_ONE) && !cif.load;

    property p_done_once;
        @(posedge i_clk) disable iff (!i_rst_n)
        cif.done |=> !cif.done;
    endproperty
    a_done_once: assert property (p_done_once)
        else $error("count exhausted twice in a row");
endmodule

// [wsg_host_model.sv]
`timescale 1ns/1ps
module wsg_host_model (
    input wire logic i_clk,
    input wire logic i_ready_out_n,
    output logic o_ads_n,
    output logic o_rdy_n
);
    logic ext_rdy_n;

    // ********************************
    // Ready loop
    // ********************************
    // Our ready out feeds back, gated with the target's own ready
    assign o_rdy_n = i_ready_out_n & ext_rdy_n;

    initial begin
        o_ads_n = 1'b1;
        ext_rdy_n = 1'b1;
    end

    // ********************************
    // Bus cycle
    // ********************************
    // lat: edges from strobe launch to ready out low, 0 if never within 40
    // gap: edges from first ready out low to the pipelined one
    task automatic run(input bit pipe, output int lat, output int gap);
        int n;
        lat = 0;
        gap = 0;
        n = 0;
        @(posedge i_clk);
        o_ads_n <= 1'b0;
        while (lat == 0 && n < 40) begin
            @(posedge i_clk);
            n++;
            if (n == 1 || n == 4)
                o_ads_n <= 1'b1;
            // Second strobe lands while the first cycle still waits
            if (pipe && n == 3)
                o_ads_n <= 1'b0;
            #1;
            if (i_ready_out_n === 1'b0)
                lat = n;
        end
        if (lat == 0) begin
            // Generator off: the target ends the cycle by itself
            @(posedge i_clk);
            ext_rdy_n <= 1'b0;
            @(posedge i_clk);
            ext_rdy_n <= 1'b1;
        end
        n = 0;
        while (pipe && gap == 0 && n < 40) begin
            @(posedge i_clk);
            n++;
            #1;
            if (i_ready_out_n === 1'b0)
                gap = n;
        end
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// [wsg_params.svh]
`ifndef WSG_PARAMS_SVH
`define WSG_PARAMS_SVH

// ***********************************
// Register port addresses
// ***********************************
`define WSG_ADDR_WAIT0 8'h72
`define WSG_ADDR_WAIT1 8'h73
`define WSG_ADDR_WAIT2 8'h74
`define WSG_ADDR_REF 8'h75

// ***********************************
// Reset values and fields
// ***********************************
`define WSG_WAIT_RST 8'hFF
`define WSG_REF_RST 4'hF
`define WSG_MEM_HI 7
`define WSG_MEM_LO 4
`define WSG_IO_HI 3
`define WSG_IO_LO 0
`define WSG_RDATA_IDLE 8'h00

// ***********************************
// Wait select encodings
// ***********************************
`define WSG_SEL_REG0 2'h0
`define WSG_SEL_REG1 2'h1
`define WSG_SEL_REG2 2'h2
`define WSG_SEL_OFF 2'h3

// ***********************************
// Wait state counts
// ***********************************
`define WSG_NP_EXTRA 5'h01
`define WSG_INTA_WAITS 5'h05
`define WSG_INT_MIN 5'h01
`define WSG_CNT_ZERO 5'h00
`define WSG_CNT_ONE 5'h01

`endif

// [wsg_pkg.sv]
package wsg_pkg;
    // Gray sequence along idle, address, wait, end of cycle
    typedef enum logic [1:0] {
        WSG_ST_IDLE = 2'h0,
        WSG_ST_ADDR = 2'h1,
        WSG_ST_WAIT = 2'h3,
        WSG_ST_END = 2'h2
    } wsg_state_t;
endpackage

// [wsg_sync.sv]
`timescale 1ns/1ps
module wsg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule

// [wsg_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
    // Sync chain (2), idle state, then address state before the count starts
    localparam int LAT0 = 4;
    // Pipelined: ready sync (2), end state, then address state
    localparam int LATP = 4;
    logic clk, rst_n, m_io, dma, refr, int_hit, inta, wr, rd;
    logic [1:0] sel;
    logic [2:0] waits;
    logic [7:0] addr, wdata, rdata;
    logic ads_n, rdy_n, rdy_out_n;
    logic [7:0] rv [3] = '{8'h20, 8'h53, 8'h0E};
    int ow [6] = '{2, 3, 4, 5, 7, 0};
    int err_count, compares, cycles, lat, gap, g1, nib;

    initial clk = 1'b0;
    always #2 clk = ~clk;

    wsg_top #(.CNT_W(5)) i_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_ADDRESS_STROBE_N(ads_n), .I_READY_N(rdy_n),
        .I_WAIT_SELECT(sel), .I_M_IO(m_io), .I_DMA_MASTER(dma), .I_REFRESH_CYC(refr),
        .I_INT_REG_HIT(int_hit), .I_INT_REG_WAITS(waits), .I_INTA_HIT(inta),
        .I_PORT_WR(wr), .I_PORT_RD(rd), .I_PORT_ADDR(addr), .I_PORT_WDATA(wdata),
        .O_PORT_RDATA(rdata), .O_READY_OUT_N(rdy_out_n)
    );

    wsg_host_model i_host (
        .i_clk(clk), .i_ready_out_n(rdy_out_n), .o_ads_n(ads_n), .o_rdy_n(rdy_n)
    );

    // ********************************
    // Access tasks
    // ********************************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(rdata, exp)
    endtask

    // Inputs stay steady for the whole cycle, well past the sampling edge
    task automatic cyc(input logic mio, input logic [1:0] s, input logic rf,
                       input logic ih, input logic [2:0] w, input logic ia,
                       input logic dm, input bit pipe, input int exp);
        @(posedge clk);
        m_io <= mio;
        sel <= s;
        refr <= rf;
        int_hit <= ih;
        waits <= w;
        inta <= ia;
        dma <= dm;
        i_host.run(pipe, lat, gap);
        if (!pipe)
            `CHK(lat, exp)
    endtask

    task automatic report_and_stop;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // Watchdog
    // ********************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        {rst_n, m_io, dma, refr, int_hit, inta, wr, rd} = '0;
        sel = 2'h0;
        waits = 3'h0;
        addr = 8'h00;
        wdata = 8'h00;
        {err_count, compares, cycles} = '0;
        repeat (4) @(posedge clk);
        `CHK(rdy_out_n, 1'b1)
        `CHK(rdata, 8'h00)
        rst_n <= 1'b1;
        for (int k = 0; k < 3; k++)
            rd_reg(8'h72 + k[7:0], 8'hFF);
        rd_reg(8'h75, 8'h0F);
        cyc(1'b1, 2'h0, 0, 0, 3'h0, 0, 0, 0, LAT0 + 16);
        $display("test reset done");
        for (int k = 0; k < 3; k++)
            wr_reg(8'h72 + k[7:0], rv[k]);
        wr_reg(8'h75, 8'hA7);
        wr_reg(8'h76, 8'hFF);
        rd_reg(8'h73, 8'h53);
        rd_reg(8'h72, 8'h20);
        rd_reg(8'h75, 8'h07);
        rd_reg(8'h76, 8'h00);
        $display("test registers done");
        for (int mio = 0; mio < 2; mio++) begin
            for (int s = 0; s < 3; s++) begin
                nib = mio ? rv[s][7:4] : rv[s][3:0];
                cyc(mio[0], s[1:0], 0, 0, 3'h0, 0, 0, 0, LAT0 + nib + 1);
            end
        end
        cyc(1'b1, 2'h1, 0, 0, 3'h0, 0, 0, 0, LAT0 + 6);
        $display("test selection done");
        cyc(1'b1, 2'h3, 0, 0, 3'h0, 0, 0, 0, 0);
        cyc(1'b0, 2'h1, 0, 0, 3'h0, 0, 0, 0, LAT0 + 4);
        cyc(1'b1, 2'h1, 1, 0, 3'h0, 0, 0, 0, LAT0 + 8);
        cyc(1'b1, 2'h3, 1, 0, 3'h0, 0, 0, 0, 0);
        $display("test disable and refresh done");
        cyc(1'b0, 2'h3, 0, 0, 3'h0, 1, 0, 0, LAT0 + 5);
        for (int k = 0; k < 6; k++)
            cyc(1'b1, 2'h1, 0, 1, ow[k][2:0], 0, 0, 0, LAT0 + (ow[k] < 2 ? 1 : ow[k]));
        cyc(1'b1, 2'h3, 0, 1, 3'h4, 0, 0, 0, LAT0 + 4);
        cyc(1'b1, 2'h1, 0, 0, 3'h0, 0, 1, 0, LAT0 + 6);
        $display("test special cycles done");
        wr_reg(8'h73, 8'h32);
        cyc(1'b1, 2'h1, 0, 0, 3'h0, 0, 0, 1, 0);
        g1 = gap;
        `CHK(g1, LATP + 3)
        cyc(1'b1, 2'h1, 0, 1, 3'h3, 0, 0, 1, 0);
        `CHK(gap, g1)
        wr_reg(8'h73, 8'h62);
        cyc(1'b1, 2'h1, 0, 0, 3'h0, 0, 0, 1, 0);
        `CHK(gap - g1, 3)
        $display("test pipelined done");
        report_and_stop();
    end
endmodule

// [wsg_top.sv]
// Behaviour
// - Inserts 1 to 16 waits non-pipelined, 0 to 15 pipelined.
// - Wait select picks one of three 8-bit wait count registers.
// - Upper nibble counts memory cycles, lower nibble I/O cycles.
// - Select 11 disables the generator for all but own register and interrupt acknowledge accesses; no wait states requested.
// - As DMA master, ready input decides when the cycle ends.
// - As slave, ready and address strobe track cycles and pipelining.
// - Non-pipelined: sample select and memory/I-O in first T2.
// - Ready output held high for each wait state of the count.
// - Select sampled on the edge after the last strobe state.
// - Own register accesses take 2 to 5, or 7, wait states.
// - Interrupt acknowledge to the device takes exactly 5 waits.
// - Own register accesses get at least one wait, even pipelined.
// - Refresh cycles use the refresh wait count register.
// - Select 11 during refresh keeps ready output inactive.
// - Other non-pipelined cycles take programmed count plus one.
// - Memory/I-O low picks I/O nibble of register 0/1/2, high memory.
// - Pipelined cycles take one wait state fewer.
// - Reset loads wait count registers 0/1/2 with FFH, the refresh register with FH.
// - Refresh register never selected by pins, used on refresh.
`timescale 1ns/1ps
`include "wsg_params.svh"
module wsg_top
    import wsg_pkg::*;
#(
    parameter int CNT_W = 5
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_ADDRESS_STROBE_N,
    input wire logic I_READY_N,
    input wire logic [1:0] I_WAIT_SELECT,
    input wire logic I_M_IO,
    input wire logic I_DMA_MASTER,
    input wire logic I_REFRESH_CYC,
    input wire logic I_INT_REG_HIT,
    input wire logic [2:0] I_INT_REG_WAITS,
    input wire logic I_INTA_HIT,
    input wire logic I_PORT_WR,
    input wire logic I_PORT_RD,
    input wire logic [7:0] I_PORT_ADDR,
    input wire logic [7:0] I_PORT_WDATA,
    output logic [7:0] O_PORT_RDATA,
    output logic O_READY_OUT_N
);

    // ***********************************
    // Pin synchronisers
    // ***********************************
    logic ads_n_s;
    logic rdy_n_s;
    logic [1:0] sel_s;
    logic m_io_s;

    wsg_sync #(.W(5), .RST_VAL(5'h1F)) u_sync (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_async({I_ADDRESS_STROBE_N, I_READY_N, I_WAIT_SELECT, I_M_IO}),
        .o_sync({ads_n_s, rdy_n_s, sel_s, m_io_s})
    );

    // ***********************************
    // Wait count registers
    // ***********************************
    logic [7:0] wait0_ff;
    logic [7:0] wait1_ff;
    logic [7:0] wait2_ff;
    logic [3:0] ref_ff;
    logic [7:0] nxt_wait0;
    logic [7:0] nxt_wait1;
    logic [7:0] nxt_wait2;
    logic [3:0] nxt_ref;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_wait0 = wait0_ff;
        nxt_wait1 = wait1_ff;
        nxt_wait2 = wait2_ff;
        nxt_ref = ref_ff;
        if (I_PORT_WR) begin
            case (I_PORT_ADDR)
                `WSG_ADDR_WAIT0: begin
                    nxt_wait0 = I_PORT_WDATA;
                end
                `WSG_ADDR_WAIT1: begin
                    nxt_wait1 = I_PORT_WDATA;
                end
                `WSG_ADDR_WAIT2: begin
                    nxt_wait2 = I_PORT_WDATA;
                end
                `WSG_ADDR_REF: begin
                    nxt_ref = I_PORT_WDATA[`WSG_IO_HI:`WSG_IO_LO];
                end
                default: begin
                    nxt_ref = ref_ff;
                end
            endcase
        end
    end

    // Reads return the stored count; unmapped addresses read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (I_PORT_RD) begin
            case (I_PORT_ADDR)
                `WSG_ADDR_WAIT0: nxt_rdata = wait0_ff;
                `WSG_ADDR_WAIT1: nxt_rdata = wait1_ff;
                `WSG_ADDR_WAIT2: nxt_rdata = wait2_ff;
                `WSG_ADDR_REF: nxt_rdata = {4'h0, ref_ff};
                default: nxt_rdata = `WSG_RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wait0_ff <= `WSG_WAIT_RST;
            wait1_ff <= `WSG_WAIT_RST;
            wait2_ff <= `WSG_WAIT_RST;
            ref_ff <= `WSG_REF_RST;
            rdata_ff <= `WSG_RDATA_IDLE;
        end else begin
            wait0_ff <= nxt_wait0;
            wait1_ff <= nxt_wait1;
            wait2_ff <= nxt_wait2;
            ref_ff <= nxt_ref;
            rdata_ff <= nxt_rdata;
        end
    end

    assign O_PORT_RDATA = rdata_ff;

    // ***********************************
    // Wait count selection
    // ***********************************
    function automatic logic [3:0] pick_nib(input logic [7:0] r, input logic mem);
        pick_nib = mem ? r[`WSG_MEM_HI:`WSG_MEM_LO] : r[`WSG_IO_HI:`WSG_IO_LO];
    endfunction

    // Pipelined cycles drop the extra wait that non-pipelined ones add
    function automatic logic [CNT_W-1:0] calc_waits(input logic [3:0] nib,
                                                    input logic piped);
        calc_waits = piped ? CNT_W'(nib) : CNT_W'(CNT_W'(nib) + `WSG_NP_EXTRA);
    endfunction

    wsg_state_t st_ff;
    wsg_state_t nxt_st;
    logic pipe_ff;
    logic nxt_pipe;
    logic pend_ff;
    logic nxt_pend;
    logic rdy_out_n_ff;
    logic nxt_rdy_out_n;
    logic [3:0] sel_nib;
    logic [CNT_W-1:0] wait_n;
    logic gen_off;
    logic sample;
    logic fire;
    logic [CNT_W-1:0] int_waits;

    wsg_cnt_if #(.CNT_W(CNT_W)) cnt_bus ();

    always_comb begin
        case (sel_s)
            `WSG_SEL_REG0: sel_nib = pick_nib(wait0_ff, m_io_s);
            `WSG_SEL_REG1: sel_nib = pick_nib(wait1_ff, m_io_s);
            `WSG_SEL_REG2: sel_nib = pick_nib(wait2_ff, m_io_s);
            default: sel_nib = 4'h0;
        endcase
    end

    // Own register accesses never run with zero waits: recovery time
    assign int_waits = (CNT_W'(I_INT_REG_WAITS) < `WSG_INT_MIN) ? CNT_W'(`WSG_INT_MIN)
                       : CNT_W'(I_INT_REG_WAITS);

    always_comb begin
        if (I_INTA_HIT) begin
            wait_n = CNT_W'(`WSG_INTA_WAITS);
        end else if (I_INT_REG_HIT) begin
            wait_n = int_waits;
        end else if (I_REFRESH_CYC) begin
            wait_n = calc_waits(ref_ff, pipe_ff);
        end else begin
            wait_n = calc_waits(sel_nib, pipe_ff);
        end
    end

    // Own accesses are answered whatever the select pins say
    assign gen_off = (sel_s == `WSG_SEL_OFF) && !I_INTA_HIT && !I_INT_REG_HIT;
    // First edge after the strobe's last active state
    assign sample = (st_ff == WSG_ST_ADDR) && ads_n_s;

    // ***********************************
    // Bus cycle tracker
    // ***********************************
    always_comb begin
        nxt_st = st_ff;
        nxt_pipe = pipe_ff;
        nxt_pend = pend_ff;
        fire = 1'b0;
        cnt_bus.load = 1'b0;
        cnt_bus.load_val = wait_n;
        case (st_ff)
            WSG_ST_IDLE: begin
                if (!ads_n_s) begin
                    nxt_st = WSG_ST_ADDR;
                    nxt_pipe = 1'b0;
                end
            end
            WSG_ST_ADDR: begin
                if (sample) begin
                    if (gen_off) begin
                        nxt_st = WSG_ST_END;
                    end else if (wait_n == `WSG_CNT_ZERO) begin
                        fire = 1'b1;
                        nxt_st = WSG_ST_END;
                    end else begin
                        cnt_bus.load = 1'b1;
                        nxt_st = WSG_ST_WAIT;
                    end
                end
            end
            WSG_ST_WAIT: begin
                if (!ads_n_s) begin
                    nxt_pend = 1'b1;
                end
                if (cnt_bus.done) begin
                    fire = 1'b1;
                    nxt_st = WSG_ST_END;
                end
            end
            WSG_ST_END: begin
                if (!ads_n_s) begin
                    nxt_pend = 1'b1;
                end
                // Cycle closes on the ready seen at the pins
                if (!rdy_n_s) begin
                    nxt_pend = 1'b0;
                    if (pend_ff || !ads_n_s) begin
                        nxt_st = WSG_ST_ADDR;
                        // DMA cycles of our own are never pipelined
                        nxt_pipe = !I_DMA_MASTER;
                    end else begin
                        nxt_st = WSG_ST_IDLE;
                        nxt_pipe = 1'b0;
                    end
                end
            end
            default: begin
                nxt_st = WSG_ST_IDLE;
            end
        endcase
        // Ready stays high while waits run; low for one clock at the end
        nxt_rdy_out_n = !fire;
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_ff <= WSG_ST_IDLE;
            pipe_ff <= 1'b0;
            pend_ff <= 1'b0;
            rdy_out_n_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            pipe_ff <= nxt_pipe;
            pend_ff <= nxt_pend;
            rdy_out_n_ff <= nxt_rdy_out_n;
        end
    end

    assign O_READY_OUT_N = rdy_out_n_ff;

    wsg_counter #(.CNT_W(CNT_W)) u_cnt (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .cif(cnt_bus)
    );

    // ***********************************
    // Checks
    // ***********************************
    property p_off_no_ready;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && gen_off) |=> O_READY_OUT_N && (st_ff == WSG_ST_END);
    endproperty
    a_off_no_ready: assert property (p_off_no_ready)
        else $error("disabled generator drove ready");

    property p_ref_off;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && I_REFRESH_CYC && gen_off) |=> O_READY_OUT_N [*2];
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("refresh with select off drove ready");

    property p_np_plus_one;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && !pipe_ff && !I_INTA_HIT && !I_INT_REG_HIT && !I_REFRESH_CYC
         && sel_s == `WSG_SEL_REG1 && m_io_s)
        |-> wait_n == CNT_W'(wait1_ff[`WSG_MEM_HI:`WSG_MEM_LO]) + `WSG_NP_EXTRA;
    endproperty
    a_np_plus_one: assert property (p_np_plus_one)
        else $error("non-pipelined count is not count plus one");

    property p_pipe_less;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && pipe_ff && !I_INTA_HIT && !I_INT_REG_HIT && !I_REFRESH_CYC
         && sel_s == `WSG_SEL_REG1 && m_io_s)
        |-> wait_n == CNT_W'(wait1_ff[`WSG_MEM_HI:`WSG_MEM_LO]);
    endproperty
    a_pipe_less: assert property (p_pipe_less)
        else $error("pipelined count wrong");

    property p_inta_five;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && I_INTA_HIT) |=> O_READY_OUT_N [*5] ##1 !O_READY_OUT_N;
    endproperty
    a_inta_five: assert property (p_inta_five)
        else $error("interrupt acknowledge did not get five waits");

    property p_int_min;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && I_INT_REG_HIT && !I_INTA_HIT) |=> O_READY_OUT_N;
    endproperty
    a_int_min: assert property (p_int_min)
        else $error("own register access got no wait state");

    property p_count_three;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (cnt_bus.load && cnt_bus.load_val == 5'h03)
        |=> O_READY_OUT_N [*3] ##1 !O_READY_OUT_N;
    endproperty
    a_count_three: assert property (p_count_three)
        else $error("ready not asserted when count exhausted");

    property p_ref_count;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (sample && I_REFRESH_CYC && !I_INTA_HIT && !I_INT_REG_HIT && !pipe_ff)
        |-> wait_n == CNT_W'(ref_ff) + `WSG_NP_EXTRA;
    endproperty
    a_ref_count: assert property (p_ref_count)
        else $error("refresh count not taken from refresh register");

    property p_sample_edge;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (cnt_bus.load) |-> st_ff == WSG_ST_ADDR && ads_n_s
        && (!$past(ads_n_s) || $past(st_ff) != WSG_ST_ADDR);
    endproperty
    a_sample_edge: assert property (p_sample_edge)
        else $error("wait count loaded outside the sampling edge");

endmodule
